// >>> hw/mls_defs.svh
`ifndef MLS_DEFS_SVH
`define MLS_DEFS_SVH
// =====================================================================
// register byte offsets
`define MLS_OFF_CTRL     12'h000
`define MLS_OFF_STATUS   12'h004
`define MLS_OFF_IRQ_ST   12'h008
`define MLS_OFF_IRQ_MASK 12'h00C
`define MLS_OFF_UBOUND   12'h010
`define MLS_OFF_LBOUND   12'h014
`define MLS_OFF_VCAP_P   12'h018
`define MLS_OFF_VCAP_M   12'h01C
`define MLS_OFF_ACAP     12'h020
`define MLS_OFF_DCAP     12'h024
`define MLS_OFF_REQ_V    12'h028
`define MLS_OFF_REQ_A    12'h02C
`define MLS_OFF_REQ_D    12'h030
`define MLS_OFF_LIM_V    12'h034
`define MLS_OFF_LIM_A    12'h038
`define MLS_OFF_LIM_D    12'h03C
// =====================================================================
// ctrl fields
`define MLS_CTRL_SOFT_EN  0
`define MLS_CTRL_POL_REV  1
// status / irq fields
`define MLS_ST_HW_POS     0
`define MLS_ST_HW_NEG     1
`define MLS_ST_SW_POS     2
`define MLS_ST_SW_NEG     3
`define MLS_ST_BOUND_ERR  4
`define MLS_ST_PAR_V      5
`define MLS_ST_PAR_A      6
`define MLS_ST_PAR_D      7
`define MLS_ST_QSTOP      8
`define MLS_ST_W          9
// =====================================================================
// reset values
`define MLS_RST_CTRL      2'h0
`define MLS_RST_UBOUND    32'h7FFFFFFF
`define MLS_RST_LBOUND    32'h80000000
`define MLS_RST_CAP       32'h7FFFFFFF
`endif

// >>> hw/mls_pkg.sv
`default_nettype none
package mls_pkg;
   typedef enum logic [1:0] {
      MLS_ST_OP_ENABLED,
      MLS_ST_QUICK_STOP,
      MLS_ST_OTHER
   } mls_drive_e;
   typedef enum logic {
      MLS_CTL_POSITION,
      MLS_CTL_VELOCITY
   } mls_loop_e;
endpackage : mls_pkg
`default_nettype wire

// >>> hw/mls_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
`include "mls_defs.svh"
module mls_supervisor #(
   parameter int W = 32
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic              pready,
   output logic              pslverr,
   output logic [31:0]       prdata,
   input  wire logic         pos_end_switch_in,
   input  wire logic         neg_end_switch_in,
   input  wire logic         op_enabled,
   input  wire logic         torque_mode,
   input  wire logic         safety_profile,
   input  wire logic         halt_req,
   input  wire logic         fault_react_req,
   input  wire logic [W-1:0] commanded_velocity,
   input  wire logic [W-1:0] commanded_torque,
   input  wire logic [W-1:0] measured_position,
   input  wire logic [W-1:0] measured_speed,
   output logic              quick_stop,
   output logic [1:0]        drive_state,
   output logic              loop_velocity,
   output logic              limit_warn,
   output logic [3:0]        limit_detail,
   output logic              param_err,
   output logic              param_limited_warn,
   output logic [2:0]        param_limited_detail,
   output logic              irq
);
   default clocking mls_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // =================================================================
   // helpers
   function automatic logic [W-1:0] umin(input logic [W-1:0] a,
                                         input logic [W-1:0] b);
      umin = (a < b) ? a : b;
   endfunction : umin

   // =================================================================
   // pin synchronisers
   logic [1:0] pos_s_r;
   logic [1:0] neg_s_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_s_r <= 2'h0;
         neg_s_r <= 2'h0;
      end else begin
         pos_s_r <= {pos_s_r[0], pos_end_switch_in};
         neg_s_r <= {neg_s_r[0], neg_end_switch_in};
      end
   end

   // =================================================================
   // registers
   logic [1:0]   ctrl_r;
   logic [W-1:0] ubound_r, lbound_r, vcap_p_r, vcap_m_r;
   logic [W-1:0] acap_r, dcap_r, req_v_r, req_a_r, req_d_r;
   logic [9:0]   irq_st_r, irq_mask_r;
   logic         stop_r;
   logic         hwp_r, hwn_r;

   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & penable & ~pwrite;
   wire soft_en = ctrl_r[`MLS_CTRL_SOFT_EN];
   wire pol_rev = ctrl_r[`MLS_CTRL_POL_REV];

   // =================================================================
   // limit evaluation, every cycle
   wire pos_sw = pol_rev ? neg_s_r[1] : pos_s_r[1];
   wire neg_sw = pol_rev ? pos_s_r[1] : neg_s_r[1];
   wire [W-1:0] req = torque_mode ? commanded_torque
                                  : commanded_velocity;
   wire req_pos = ~req[W-1] & (req != '0);
   wire req_neg = req[W-1];
   wire hw_pos = op_enabled & req_pos & pos_sw;
   wire hw_neg = op_enabled & req_neg & neg_sw;
   wire sw_pos = op_enabled & soft_en & req_pos &
                 ($signed(measured_position) > $signed(ubound_r));
   wire sw_neg = op_enabled & soft_en & req_neg &
                 ($signed(measured_position) < $signed(lbound_r));
   wire trip = hw_pos | hw_neg | sw_pos | sw_neg;
   wire standstill = (measured_speed == '0);
   wire stop_nxt = trip | (stop_r & ~standstill);
   wire bound_err = $signed(ubound_r) < $signed(lbound_r);

   // =================================================================
   // profile clamps
   wire [W-1:0] vcap = umin(vcap_p_r, vcap_m_r);
   wire lim_v = req_v_r > vcap;
   wire lim_a = req_a_r > acap_r;
   wire lim_d = req_d_r > dcap_r;
   wire [W-1:0] out_v = umin(req_v_r, vcap);
   wire [W-1:0] out_a = umin(req_a_r, acap_r);
   wire [W-1:0] out_d = umin(req_d_r, dcap_r);

   // =================================================================
   // outputs
   assign quick_stop  = stop_r;
   assign drive_state = stop_r ? 2'(mls_pkg::MLS_ST_QUICK_STOP)
                      : op_enabled ? 2'(mls_pkg::MLS_ST_OP_ENABLED)
                      : 2'(mls_pkg::MLS_ST_OTHER);
   // safety profile wins, it always needs the position loop
   assign loop_velocity = ~safety_profile & torque_mode &
                          (halt_req | stop_r | fault_react_req);
   assign limit_detail = {sw_neg, sw_pos, hwn_r, hwp_r};
   assign limit_warn   = |limit_detail;
   assign param_err    = bound_err;
   assign param_limited_detail = {lim_d, lim_a, lim_v};
   assign param_limited_warn   = |param_limited_detail;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign irq = |(irq_st_r & irq_mask_r);

   wire [9:0] events = {param_limited_warn, stop_r, lim_d, lim_a, lim_v,
                        bound_err, sw_neg, sw_pos, hwn_r, hwp_r};
   wire rd_irq = rd_en & (paddr == `MLS_OFF_IRQ_ST);

   // =================================================================
   // read mux
   logic [31:0] rd_mux;
   always_comb begin
      unique case (paddr)
         `MLS_OFF_CTRL:     rd_mux = {30'h0, ctrl_r};
         `MLS_OFF_STATUS:   rd_mux = {22'h0, events};
         `MLS_OFF_IRQ_ST:   rd_mux = {22'h0, irq_st_r};
         `MLS_OFF_IRQ_MASK: rd_mux = {22'h0, irq_mask_r};
         `MLS_OFF_UBOUND:   rd_mux = 32'(ubound_r);
         `MLS_OFF_LBOUND:   rd_mux = 32'(lbound_r);
         `MLS_OFF_VCAP_P:   rd_mux = 32'(vcap_p_r);
         `MLS_OFF_VCAP_M:   rd_mux = 32'(vcap_m_r);
         `MLS_OFF_ACAP:     rd_mux = 32'(acap_r);
         `MLS_OFF_DCAP:     rd_mux = 32'(dcap_r);
         `MLS_OFF_REQ_V:    rd_mux = 32'(req_v_r);
         `MLS_OFF_REQ_A:    rd_mux = 32'(req_a_r);
         `MLS_OFF_REQ_D:    rd_mux = 32'(req_d_r);
         `MLS_OFF_LIM_V:    rd_mux = 32'(out_v);
         `MLS_OFF_LIM_A:    rd_mux = 32'(out_a);
         `MLS_OFF_LIM_D:    rd_mux = 32'(out_d);
         default:           rd_mux = 32'h0;
      endcase
   end

   // =================================================================
   // state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_r <= 1'b0;
         hwp_r  <= 1'b0;
         hwn_r  <= 1'b0;
      end else begin
         stop_r <= stop_nxt;
         hwp_r  <= hw_pos;
         hwn_r  <= hw_neg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_r <= 10'h0;
      end else begin
         // a new event in the read cycle survives the clear
         irq_st_r <= (rd_irq ? 10'h0 : irq_st_r) | events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r     <= `MLS_RST_CTRL;
         irq_mask_r <= 10'h0;
         ubound_r   <= W'(`MLS_RST_UBOUND);
         lbound_r   <= W'(`MLS_RST_LBOUND);
         vcap_p_r   <= W'(`MLS_RST_CAP);
         vcap_m_r   <= W'(`MLS_RST_CAP);
         acap_r     <= W'(`MLS_RST_CAP);
         dcap_r     <= W'(`MLS_RST_CAP);
         req_v_r    <= '0;
         req_a_r    <= '0;
         req_d_r    <= '0;
      end else if (wr_en) begin
         unique case (paddr)
            `MLS_OFF_CTRL:     ctrl_r     <= pwdata[1:0];
            `MLS_OFF_IRQ_MASK: irq_mask_r <= pwdata[9:0];
            `MLS_OFF_UBOUND:   ubound_r   <= W'(pwdata);
            `MLS_OFF_LBOUND:   lbound_r   <= W'(pwdata);
            `MLS_OFF_VCAP_P:   vcap_p_r   <= W'(pwdata);
            `MLS_OFF_VCAP_M:   vcap_m_r   <= W'(pwdata);
            `MLS_OFF_ACAP:     acap_r     <= W'(pwdata);
            `MLS_OFF_DCAP:     dcap_r     <= W'(pwdata);
            `MLS_OFF_REQ_V:    req_v_r    <= W'(pwdata);
            `MLS_OFF_REQ_A:    req_a_r    <= W'(pwdata);
            `MLS_OFF_REQ_D:    req_d_r    <= W'(pwdata);
            default: ;
         endcase
      end
   end

   // =================================================================
   // checks
   a_hw_pos_stop: assert property (
      hw_pos |=> quick_stop)
      else $error("positive switch did not stop");
   a_hw_neg_stop: assert property (
      hw_neg |=> quick_stop)
      else $error("negative switch did not stop");
   a_idle_hw: assert property (
      !op_enabled |=> limit_detail[1:0] == 2'h0)
      else $error("hardware limit outside enabled state");
   a_idle_sw: assert property (
      !op_enabled |-> limit_detail[3:2] == 2'h0)
      else $error("soft limit outside enabled state");
   a_rev_pos_stop: assert property (
      (pol_rev && op_enabled && req_pos && neg_s_r[1]) |=> quick_stop)
      else $error("reversed negative pin did not stop");
   a_rev_neg_stop: assert property (
      (pol_rev && op_enabled && req_neg && pos_s_r[1]) |=> quick_stop)
      else $error("reversed positive pin did not stop");
   a_rev_pos_quiet: assert property (
      (pol_rev && !neg_s_r[1]) |=> !limit_detail[0])
      else $error("reversed positive role wrong");
   a_rev_neg_quiet: assert property (
      (pol_rev && !pos_s_r[1]) |=> !limit_detail[1])
      else $error("reversed negative role wrong");
   a_away_quiet: assert property (
      (!trip && !stop_r) |=> !quick_stop)
      else $error("stop without cause");
   a_away_hw_pos: assert property (
      req_neg |=> !limit_detail[0])
      else $error("positive warning on move away");
   a_away_hw_neg: assert property (
      req_pos |=> !limit_detail[1])
      else $error("negative warning on move away");
   a_away_sw_pos: assert property (
      !req_pos |-> !limit_detail[2])
      else $error("soft positive warning on move away");
   a_away_sw_neg: assert property (
      !req_neg |-> !limit_detail[3])
      else $error("soft negative warning on move away");
   a_state_qs: assert property (
      quick_stop |-> drive_state == 2'(mls_pkg::MLS_ST_QUICK_STOP))
      else $error("state not quick stop");
   a_state_op: assert property (
      (!quick_stop && op_enabled) |->
         drive_state == 2'(mls_pkg::MLS_ST_OP_ENABLED))
      else $error("state not operation enabled");
   a_state_other: assert property (
      (!quick_stop && !op_enabled) |->
         drive_state == 2'(mls_pkg::MLS_ST_OTHER))
      else $error("state not other");
   a_stop_ends: assert property (
      (quick_stop && measured_speed == '0 && !trip) |=> !quick_stop)
      else $error("stop kept at standstill");
   a_hw_warn: assert property (
      hw_pos |=> limit_warn && limit_detail[0])
      else $error("hardware warning missing");
   a_hw_neg_warn: assert property (
      hw_neg |=> limit_warn && limit_detail[1])
      else $error("negative hardware warning missing");
   a_hw_warn_end: assert property (
      (!hw_pos && !hw_neg) |=> limit_detail[1:0] == 2'h0)
      else $error("hardware warning outlived limit");
   a_sw_stop: assert property (
      sw_pos |=> quick_stop)
      else $error("soft upper limit did not stop");
   a_sw_neg_stop: assert property (
      sw_neg |=> quick_stop)
      else $error("soft lower limit did not stop");
   a_soft_off: assert property (
      !soft_en |-> limit_detail[3:2] == 2'h0)
      else $error("soft limit while disabled");
   a_sw_pos_cause: assert property (
      limit_detail[2] |-> $signed(measured_position) > $signed(ubound_r))
      else $error("soft upper warning inside bound");
   a_sw_neg_cause: assert property (
      limit_detail[3] |-> $signed(measured_position) < $signed(lbound_r))
      else $error("soft lower warning inside bound");
   a_sw_warn: assert property (
      sw_neg |-> limit_detail[3] && limit_warn)
      else $error("soft warning missing");
   a_sw_pos_warn: assert property (
      sw_pos |-> limit_detail[2] && limit_warn)
      else $error("soft upper warning missing");
   a_sw_warn_end: assert property (
      (!sw_pos && !sw_neg) |-> limit_detail[3:2] == 2'h0)
      else $error("soft warning outlived limit");
   a_bound_err: assert property (
      ($signed(ubound_r) < $signed(lbound_r)) |-> param_err)
      else $error("bound error missing");
   a_clamp_v: assert property (
      out_v <= vcap_p_r && out_v <= vcap_m_r)
      else $error("speed not clamped");
   a_clamp_v_pass: assert property (
      (req_v_r <= vcap_p_r && req_v_r <= vcap_m_r) |-> out_v == req_v_r)
      else $error("speed clamped needlessly");
   a_clamp_v_cap: assert property (
      (req_v_r > vcap_p_r && vcap_p_r <= vcap_m_r) |-> out_v == vcap_p_r)
      else $error("speed not at profile cap");
   a_clamp_ad: assert property (
      out_a <= acap_r && out_d <= dcap_r)
      else $error("accel not clamped");
   a_clamp_a_pass: assert property (
      (req_a_r <= acap_r) |-> out_a == req_a_r)
      else $error("accel clamped needlessly");
   a_clamp_a_cap: assert property (
      (req_a_r > acap_r) |-> out_a == acap_r)
      else $error("accel not at cap");
   a_clamp_d_pass: assert property (
      (req_d_r <= dcap_r) |-> out_d == req_d_r)
      else $error("decel clamped needlessly");
   a_clamp_d_cap: assert property (
      (req_d_r > dcap_r) |-> out_d == dcap_r)
      else $error("decel not at cap");
   a_par_warn: assert property (
      (out_v != req_v_r || out_d != req_d_r) |-> param_limited_warn)
      else $error("limited warning missing");
   a_par_a_warn: assert property (
      (out_a != req_a_r) |-> param_limited_detail[1])
      else $error("accel limited detail missing");
   a_par_quiet: assert property (
      (out_v == req_v_r && out_a == req_a_r && out_d == req_d_r) |->
         !param_limited_warn)
      else $error("limited warning without clamp");
   a_torque_vel: assert property (
      (torque_mode && !safety_profile &&
       (halt_req || fault_react_req || quick_stop)) |-> loop_velocity)
      else $error("torque stop not velocity controlled");
   a_speed_pos: assert property (
      !torque_mode |-> !loop_velocity)
      else $error("velocity loop outside torque mode");
   a_safety_pos: assert property (
      safety_profile |-> !loop_velocity)
      else $error("safety profile not position");
   a_hold_stop: assert property (
      (quick_stop && measured_speed != '0) |=> quick_stop)
      else $error("stop released while moving");
   a_stop_cause: assert property (
      $rose(quick_stop) |-> $past(trip))
      else $error("stop raised without limit");
   a_irq_sticky: assert property (
      (events != 10'h0) |=> (irq_st_r & $past(events)) == $past(events))
      else $error("event lost from status");
   a_irq_clear: assert property (
      (rd_irq && events == 10'h0) |=> irq_st_r == 10'h0)
      else $error("status not cleared by read");
endmodule : mls_supervisor
`default_nettype wire

// >>> tb/mls_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// ======
// far side: end switches and a motor that coasts down
module mls_far_side (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        quick_stop,
   input  wire logic        pos_hit,
   input  wire logic        neg_hit,
   output logic             pos_end_switch_in,
   output logic             neg_end_switch_in,
   output logic [31:0]      measured_speed
);
   assign pos_end_switch_in = pos_hit;
   assign neg_end_switch_in = neg_hit;
   // slow ramp so the stop outlives the switch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         measured_speed <= 32'h20;
      else if (quick_stop && measured_speed != 32'h0)
         measured_speed <= measured_speed - 32'h1;
      else if (!quick_stop)
         measured_speed <= 32'h20;
   end
endmodule : mls_far_side
`default_nettype wire

// >>> tb/motion_limit_supervisor_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "mls_defs.svh"
module motion_limit_supervisor_bench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, smp = 0;
   logic pos_hit = 0, neg_hit = 0, op_enabled = 1, torque_mode = 0;
   logic safety_profile = 0, halt_req = 0, fault_react_req = 0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, cmd_v = 32'h0, cmd_t = 32'h0, pos = 32'h0;
   logic [31:0] rnd = 32'hF26BD793;
   wire logic pready, pslverr, pse, nse, quick_stop, loop_velocity, irq;
   wire logic limit_warn, param_err, param_limited_warn;
   wire logic [1:0] drive_state;
   wire logic [2:0] param_limited_detail;
   wire logic [3:0] limit_detail;
   wire logic [31:0] prdata, measured_speed;
   wire logic [14:0] outs = {irq, quick_stop, drive_state, limit_warn,
      limit_detail, param_err, loop_velocity, param_limited_warn,
      param_limited_detail};
   logic [14:0] oq[$], omq[$];
   logic [31:0] rq[$], mq[$];
   int err_total = 0, num_checks = 0, cycles = 0;
   mls_supervisor mls_supervisor_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .pos_end_switch_in(pse), .neg_end_switch_in(nse),
      .op_enabled(op_enabled), .torque_mode(torque_mode),
      .safety_profile(safety_profile), .halt_req(halt_req),
      .fault_react_req(fault_react_req), .commanded_velocity(cmd_v),
      .commanded_torque(cmd_t), .measured_position(pos),
      .measured_speed(measured_speed), .quick_stop(quick_stop),
      .drive_state(drive_state), .loop_velocity(loop_velocity),
      .limit_warn(limit_warn), .limit_detail(limit_detail),
      .param_err(param_err), .param_limited_warn(param_limited_warn),
      .param_limited_detail(param_limited_detail), .irq(irq));
   mls_far_side mls_far_side_i (.pclk(pclk), .presetn(presetn),
      .quick_stop(quick_stop), .pos_hit(pos_hit), .neg_hit(neg_hit),
      .pos_end_switch_in(pse), .neg_end_switch_in(nse),
      .measured_speed(measured_speed));
   always #12.5 pclk = ~pclk;
   // ======
   // checking
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic complete_run();
      if (err_total == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task automatic cmp_out(input logic [14:0] e, m, s);
      num_checks++;
      if ((s & m) !== (e & m)) begin
         err_total++;
         $display("Error outputs expected %h seen %h", e & m, s & m);
      end
   endtask : cmp_out
   task automatic cmp_reg(input logic [31:0] e, m, s, input string n);
      num_checks++;
      if ((s & m) !== (e & m)) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e & m, s & m);
      end
   endtask : cmp_reg
   always @(posedge pclk) begin
      if (smp)
         cmp_out(oq.pop_front(), omq.pop_front(), outs);
      if (psel && penable && pready === 1'b1 && !pwrite)
         cmp_reg(rq.pop_front(), mq.pop_front(), prdata, "prdata");
      if (psel && penable && pready === 1'b1)
         cmp_reg(32'h0, 32'h1, {31'h0, pslverr}, "pslverr");
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         complete_run();
      end
   end
   // ======
   // stimulus
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, m);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) begin
         rq.push_back(d);
         mq.push_back(m);
      end
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [14:0] e, m);
      oq.push_back(e);
      omq.push_back(m);
      smp <= 1'b1;
      @(posedge pclk);
      smp <= 1'b0;
      @(posedge pclk);
   endtask : chk
   // torque mode flips the velocity sign, so the wrong source shows
   task automatic lim(input logic [31:0] v, input logic p, n, tm,
                      input logic [31:0] ps, input logic stop,
                      input logic [3:0] d);
      torque_mode <= tm;
      pos_hit <= p;
      neg_hit <= n;
      pos <= ps;
      // let the pins pass the synchroniser before anything moves
      repeat (3) @(posedge pclk);
      cmd_v <= tm ? -v : v;
      cmd_t <= tm ? v : -v;
      repeat (6) @(posedge pclk);
      if (stop) begin
         chk({2'b01, 2'b01, 1'b1, d, 1'b0, tm, 4'h0},
             {1'b0, 9'h1FF, tm, 4'h0});
         pos_hit <= 1'b0;
         neg_hit <= 1'b0;
         pos <= 32'h0;
         repeat (3) @(posedge pclk);
         chk(15'h2800, 15'h3800);
         repeat (40) @(posedge pclk);
         chk(15'h0, 15'h3800);
      end else
         chk({2'b0, !op_enabled, 12'h0}, 15'h3FE0);
      // zero request trips nothing, so the next set-up starts clean
      cmd_v <= 32'h0;
      cmd_t <= 32'h0;
   endtask : lim
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `MLS_OFF_CTRL, 32'h0, 32'hFFFFFFFF);
      apb(0, `MLS_OFF_UBOUND, `MLS_RST_UBOUND, 32'hFFFFFFFF);
      apb(0, `MLS_OFF_LBOUND, `MLS_RST_LBOUND, 32'hFFFFFFFF);
      apb(1, 12'h100, 32'hFFFFFFFF, 32'h0);
      apb(0, 12'h100, 32'h0, 32'hFFFFFFFF);
      lim(32'hA, 1, 0, 0, 32'h0, 1, 4'h1);
      lim(32'hFFFFFFF6, 1, 0, 0, 32'h0, 0, 4'h0);
      lim(32'hA, 0, 1, 0, 32'h0, 0, 4'h0);
      lim(32'hFFFFFFF6, 0, 1, 0, 32'h0, 1, 4'h2);
      lim(32'hA, 1, 0, 1, 32'h0, 1, 4'h1);
      apb(1, `MLS_OFF_CTRL, 32'h2, 32'h0);
      lim(32'hFFFFFFF6, 1, 0, 0, 32'h0, 1, 4'h2);
      lim(32'hA, 0, 1, 0, 32'h0, 1, 4'h1);
      lim(32'hA, 1, 0, 0, 32'h0, 0, 4'h0);
      apb(1, `MLS_OFF_CTRL, 32'h1, 32'h0);
      apb(1, `MLS_OFF_UBOUND, 32'h64, 32'h0);
      apb(1, `MLS_OFF_LBOUND, 32'hFFFFFF9C, 32'h0);
      rnd = lfsr(rnd);
      lim(32'hA, 0, 0, 0, {26'h0, rnd[5:0]}, 0, 4'h0);
      lim(32'hA, 0, 0, 0, 32'hC8, 1, 4'h4);
      lim(32'hFFFFFFF6, 0, 0, 0, 32'hC8, 0, 4'h0);
      lim(32'hFFFFFFF6, 0, 0, 0, 32'hFFFFFF38, 1, 4'h8);
      op_enabled <= 1'b0;
      lim(32'hA, 1, 0, 0, 32'hC8, 0, 4'h0);
      op_enabled <= 1'b1;
      apb(1, `MLS_OFF_UBOUND, 32'hFFFFFF38, 32'h0);
      chk(15'h20, 15'h20);
      apb(0, `MLS_OFF_STATUS, 32'h10, 32'h10);
      apb(1, `MLS_OFF_UBOUND, 32'h64, 32'h0);
      apb(1, `MLS_OFF_VCAP_P, 32'h32, 32'h0);
      apb(1, `MLS_OFF_VCAP_M, 32'h1E, 32'h0);
      apb(1, `MLS_OFF_ACAP, 32'hA, 32'h0);
      apb(1, `MLS_OFF_DCAP, 32'hA, 32'h0);
      apb(1, `MLS_OFF_REQ_V, 32'h28, 32'h0);
      apb(1, `MLS_OFF_REQ_A, 32'h5, 32'h0);
      apb(1, `MLS_OFF_REQ_D, 32'h14, 32'h0);
      apb(0, `MLS_OFF_LIM_V, 32'h1E, 32'hFFFFFFFF);
      apb(0, `MLS_OFF_LIM_A, 32'h5, 32'hFFFFFFFF);
      apb(0, `MLS_OFF_LIM_D, 32'hA, 32'hFFFFFFFF);
      chk(15'hD, 15'hF);
      apb(1, `MLS_OFF_VCAP_P, 32'h14, 32'h0);
      apb(0, `MLS_OFF_LIM_V, 32'h14, 32'hFFFFFFFF);
      torque_mode <= 1'b1;
      halt_req <= 1'b1;
      chk(15'h10, 15'h10);
      halt_req <= 1'b0;
      fault_react_req <= 1'b1;
      chk(15'h10, 15'h10);
      fault_react_req <= 1'b0;
      safety_profile <= 1'b1;
      halt_req <= 1'b1;
      chk(15'h0, 15'h10);
      safety_profile <= 1'b0;
      halt_req <= 1'b0;
      apb(1, `MLS_OFF_IRQ_MASK, 32'h3FF, 32'h0);
      chk(15'h4000, 15'h4000);
      apb(1, `MLS_OFF_IRQ_MASK, 32'h0, 32'h0);
      chk(15'h0, 15'h4000);
      apb(1, `MLS_OFF_IRQ_MASK, 32'hF, 32'h0);
      chk(15'h4000, 15'h4000);
      apb(0, `MLS_OFF_IRQ_ST, 32'hF, 32'hF);
      apb(0, `MLS_OFF_IRQ_ST, 32'h0, 32'hF);
      chk(15'h0, 15'h4000);
      complete_run();
   end
endmodule : motion_limit_supervisor_bench
`default_nettype wire
